// [logic/ebrw_pkg.sv]
// Package of constants and carrier types for the external bus READY wait-state controller.
// Assumes a single system clock domain; every user writes ebrw_pkg::name.
package ebrw_pkg;

	// ****************************************************************
	// Field widths and limits
	// ****************************************************************
	localparam int unsigned PHASE_W       = 6;
	localparam logic [5:0]  ACCESS_MIN    = 6'h01;
	localparam logic [5:0]  ACCESS_MAX    = 6'h20;
	localparam int unsigned SYNC_STAGES   = 2;
	localparam logic [5:0]  PHASE_RESET   = 6'h00;

	// ****************************************************************
	// Carrier types
	// ****************************************************************
	// Per-cycle configuration presented with a start request.
	typedef struct packed {
		logic       ready_en;
		logic       ready_active_high;
		logic       ready_async;
		logic [5:0] access_phase_length;
	} ebrw_cfg_t;

	// Status of the running cycle.
	typedef struct packed {
		logic busy;
		logic in_wait;
		logic done;
	} ebrw_stat_t;

	typedef enum logic [1:0] {
		EBRW_IDLE,
		EBRW_ACCESS,
		EBRW_READY_WAIT
	} ebrw_state_t;

endpackage

// [logic/ebrw_ready_sync.sv]
// Two-flop synchronizer for the READY pin in asynchronous mode.
// Assumes the pin is unrelated to clk; only the second flop is read downstream.
`timescale 1ns/10ps
module ebrw_ready_sync (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic reset,
	// Pin side.
	input  wire logic pin_in,
	// Synchronized level.
	output logic      sync_out
);

	logic meta_q;
	logic sync_q;

	// Two register stages, the first read only by the second.
	always_ff @(posedge clk) begin
		if (reset) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule

// [logic/ebrw_ready_ctrl.sv]
// READY wait-state control of one external bus cycle's access phase.
// Assumes the bus sequencer asserts start for one cycle and that clk is the bus reference clock.
`timescale 1ns/10ps
module ebrw_ready_ctrl (
	// Clock and reset.
	input  wire logic               clk,
	input  wire logic               reset,
	// Cycle request from the bus sequencer.
	input  wire logic               start,
	input  wire ebrw_pkg::ebrw_cfg_t cfg,
	// READY pin from the external circuit.
	input  wire logic               ready_pin,
	// Cycle status towards the sequencer.
	output ebrw_pkg::ebrw_stat_t    stat,
	output logic [5:0]              ready_wait_phase
);

	// ****************************************************************
	// Input conditioning
	// ****************************************************************
	logic ready_async_lvl;
	logic ready_sync_lvl_q;
	logic ready_raw_active;
	logic ready_sel;

	ebrw_ready_sync u_sync (
		.clk      (clk),
		.reset    (reset),
		.pin_in   (ready_pin),
		.sync_out (ready_async_lvl)
	);

	// Synchronous mode uses a single capture flop, the pin's own input register.
	always_ff @(posedge clk) begin
		if (reset) begin
			ready_sync_lvl_q <= 1'b0;
		end else begin
			ready_sync_lvl_q <= ready_pin;
		end
	end

	ebrw_pkg::ebrw_cfg_t cfg_q;
	ebrw_pkg::ebrw_cfg_t cfg_d;

	// Pick the path by mode, then apply the programmed polarity.
	assign ready_sel        = cfg_q.ready_async ? ready_async_lvl : ready_sync_lvl_q;
	assign ready_raw_active = cfg_q.ready_active_high ? ready_sel : ~ready_sel;

	// ****************************************************************
	// Cycle sequencing
	// ****************************************************************
	ebrw_pkg::ebrw_state_t state_q;
	ebrw_pkg::ebrw_state_t state_d;
	logic [5:0]            cnt_q;
	logic [5:0]            cnt_d;
	logic [5:0]            wait_q;
	logic [5:0]            wait_d;
	logic                  done_q;
	logic                  done_d;
	logic [5:0]            len_clip;
	logic                  access_end;
	logic                  async_hold;

	// Clamp the programmed length into its legal range.
	function automatic logic [5:0] clip_len(input logic [5:0] l);
		if (l < ebrw_pkg::ACCESS_MIN) begin
			clip_len = ebrw_pkg::ACCESS_MIN;
		end else if (l > ebrw_pkg::ACCESS_MAX) begin
			clip_len = ebrw_pkg::ACCESS_MAX;
		end else begin
			clip_len = l;
		end
	endfunction

	assign len_clip   = clip_len(cfg.access_phase_length);
	assign access_end = (cnt_q == 6'h01);
	// Asynchronous mode with READY enabled always spends one waitstate for synchronizer latency.
	assign async_hold = cfg_q.ready_async && (wait_q == 6'h00);

	// Next-state logic for the access and ready-wait phases.
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		wait_d  = wait_q;
		cfg_d   = cfg_q;
		done_d  = 1'b0;
		unique case (state_q)
			ebrw_pkg::EBRW_IDLE: begin
				if (start) begin
					cfg_d   = cfg;
					cnt_d   = len_clip;
					wait_d  = ebrw_pkg::PHASE_RESET;
					state_d = ebrw_pkg::EBRW_ACCESS;
				end
			end
			ebrw_pkg::EBRW_ACCESS: begin
				if (!access_end) begin
					cnt_d = cnt_q - 6'h01;
				end else if (!cfg_q.ready_en) begin
					done_d  = 1'b1;
					state_d = ebrw_pkg::EBRW_IDLE;
				end else if (ready_raw_active && !async_hold) begin
					done_d  = 1'b1;
					state_d = ebrw_pkg::EBRW_IDLE;
				end else begin
					wait_d  = wait_q + 6'h01;
					state_d = ebrw_pkg::EBRW_READY_WAIT;
				end
			end
			ebrw_pkg::EBRW_READY_WAIT: begin
				if (ready_raw_active) begin
					done_d  = 1'b1;
					state_d = ebrw_pkg::EBRW_IDLE;
				end else if (wait_q != 6'h3f) begin
					wait_d = wait_q + 6'h01;
				end
			end
		endcase
	end

	// State registers.
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= ebrw_pkg::EBRW_IDLE;
			cnt_q   <= ebrw_pkg::PHASE_RESET;
			wait_q  <= ebrw_pkg::PHASE_RESET;
			cfg_q   <= '0;
			done_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			wait_q  <= wait_d;
			cfg_q   <= cfg_d;
			done_q  <= done_d;
		end
	end

	// Status outputs come from registers.
	// One continuous assignment drives the whole status word, so the struct has a single driver.
	assign stat = '{busy:    (state_q != ebrw_pkg::EBRW_IDLE),
	                in_wait: (state_q == ebrw_pkg::EBRW_READY_WAIT),
	                done:    done_q};
	assign ready_wait_phase  = wait_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	sequence s_access_last;
		state_q == ebrw_pkg::EBRW_ACCESS && access_end;
	endsequence

	property p_no_ready_no_wait;
		@(posedge clk) disable iff (reset)
		s_access_last and !cfg_q.ready_en |=> done_q && state_q == ebrw_pkg::EBRW_IDLE;
	endproperty
	a_no_ready_no_wait: assert property (p_no_ready_no_wait) else $error("Cycle without READY did not end.");

	property p_inactive_waits;
		@(posedge clk) disable iff (reset)
		s_access_last and cfg_q.ready_en && !ready_raw_active |=> state_q == ebrw_pkg::EBRW_READY_WAIT;
	endproperty
	a_inactive_waits: assert property (p_inactive_waits) else $error("No waitstate on inactive READY.");

	property p_active_ends;
		@(posedge clk) disable iff (reset)
		state_q == ebrw_pkg::EBRW_READY_WAIT && ready_raw_active |=> done_q && !stat.busy;
	endproperty
	a_active_ends: assert property (p_active_ends) else $error("Active READY did not end cycle.");

	property p_async_min_wait;
		@(posedge clk) disable iff (reset)
		done_q && cfg_q.ready_async && cfg_q.ready_en |-> wait_q != 6'h00;
	endproperty
	a_async_min_wait: assert property (p_async_min_wait) else $error("Async READY cycle lacked a waitstate.");

	property p_ignore_during_access;
		@(posedge clk) disable iff (reset)
		state_q == ebrw_pkg::EBRW_ACCESS && !access_end |=> !done_q;
	endproperty
	a_ignore_during_access: assert property (p_ignore_during_access) else $error("Cycle ended inside access.");

	property p_access_length;
		@(posedge clk) disable iff (reset)
		start && !stat.busy && cfg.access_phase_length == 6'h03 |=> stat.busy [*3];
	endproperty
	a_access_length: assert property (p_access_length) else $error("Access phase shorter than programmed.");

	// The decision is checked against the pin itself, so a wrong path or polarity both show up.
	property p_polarity;
		@(posedge clk) disable iff (reset)
		!$past(reset) && !$past(reset, 2) |->
			ready_raw_active == (cfg_q.ready_active_high ==
				(cfg_q.ready_async ? $past(ready_pin, 2) : $past(ready_pin)));
	endproperty
	a_polarity: assert property (p_polarity) else $error("READY polarity misapplied.");

	property p_sync_path;
		@(posedge clk) disable iff (reset)
		!cfg_q.ready_async && !$past(reset) |-> ready_sel == $past(ready_pin);
	endproperty
	a_sync_path: assert property (p_sync_path) else $error("Sync READY path not single-stage.");

	property p_async_later;
		@(posedge clk) disable iff (reset)
		cfg_q.ready_async && !$past(reset) && !$past(reset, 2) |-> ready_sel == $past(ready_pin, 2);
	endproperty
	a_async_later: assert property (p_async_later) else $error("Async READY path not two-stage.");

endmodule

// [testbench/ebrw_ready_model.sv]
// Model of the external circuit that drives the READY pin.
// Assumes the bench sets want and the polarity, and that clk is the bus reference clock.
`timescale 1ns/10ps
module ebrw_ready_model (
	// Clock and control from the bench.
	input  wire logic clk,
	input  wire logic want,
	input  wire logic active_high,
	// End of the running cycle.
	input  wire logic done,
	// READY pin.
	output logic      ready_pin
);
	logic act_q;

	// Changes READY only after a clock edge, holds it for whole periods, drops it as the cycle ends.
	always_ff @(posedge clk) begin
		act_q <= want & ~done;
	end

	// Applies the chosen active level to the pin.
	assign ready_pin = active_high ? act_q : ~act_q;
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the READY wait-state controller.
// Assumes the controller and the READY model share one 10 MHz clock.
`timescale 1ns/10ps
module tb_top;
	logic                 clk;
	logic                 reset;
	logic                 start;
	logic                 want;
	logic                 ready_pin;
	logic [5:0]           wait_n;
	ebrw_pkg::ebrw_cfg_t  cfg;
	ebrw_pkg::ebrw_stat_t stat;
	int                   n_fail;
	int                   num_checks;
	int                   n;
	int                   n_wt;

	ebrw_ready_ctrl dut (.clk(clk), .reset(reset), .start(start), .cfg(cfg), .ready_pin(ready_pin),
		.stat(stat), .ready_wait_phase(wait_n));
	ebrw_ready_model u_model (.clk(clk), .want(want), .active_high(cfg.ready_active_high),
		.done(stat.done), .ready_pin(ready_pin));

	// Makes the 100 ns clock.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Compares one value and counts the outcome.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic tally_and_finish();
		$display("checks=%0d fails=%0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Runs one cycle and counts edges from the start edge to done; rel below zero holds READY from the outset.
	task automatic run(input logic en, hi, as, input logic [5:0] len, input int rel);
		@(posedge clk);
		cfg <= {en, hi, as, len};
		if (rel < 0) begin
			want <= 1'b1;
			repeat (3) @(posedge clk);
		end
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		n = 0;
		n_wt = 0;
		while (stat.done !== 1'b1) begin
			@(posedge clk);
			if (n == rel) want <= 1'b1;
			#1;
			n++;
			if (stat.in_wait === 1'b1) n_wt++;
			if (n > 200) begin
				n_fail++;
				tally_and_finish();
			end
		end
		chk(stat.busy, 1'b0);
		@(posedge clk);
		want <= 1'b0;
	endtask

	// Cycles without READY control end after their phases, at both length bounds.
	task automatic t_noready();
		run(1'b0, 1'b1, 1'b0, 6'h03, 999);
		chk(n, 3);
		chk(wait_n, 0);
		chk(n_wt, 0);
		run(1'b0, 1'b1, 1'b0, 6'h20, 999);
		chk(n, 32);
		run(1'b0, 1'b1, 1'b0, 6'h01, 999);
		chk(n, 1);
		run(1'b0, 1'b1, 1'b0, 6'h00, 999);
		chk(n, 1);
		run(1'b0, 1'b1, 1'b0, 6'h3f, 999);
		chk(n, 32);
		$display("test noready done");
	endtask

	// Synchronous READY active from the outset, high and low active.
	task automatic t_sync();
		run(1'b1, 1'b1, 1'b0, 6'h05, -1);
		chk(n, 5);
		chk(wait_n, 0);
		run(1'b1, 1'b0, 1'b0, 6'h02, -1);
		chk(n, 2);
		$display("test sync done");
	endtask

	// READY late: waitstates are inserted until it is seen active.
	task automatic t_wait();
		run(1'b1, 1'b1, 1'b0, 6'h02, 4);
		chk(wait_n, 6);
		chk(n, 8);
		chk(n_wt, 6);
		$display("test wait done");
	endtask

	// A start while busy is ignored; a reset in mid-cycle clears all status.
	task automatic t_refuse_reset();
		@(posedge clk);
		cfg   <= {1'b1, 1'b1, 1'b0, 6'h04};
		start <= 1'b1;
		@(posedge clk);
		cfg   <= {1'b0, 1'b1, 1'b0, 6'h01};
		@(posedge clk);
		start <= 1'b0;
		repeat (5) @(posedge clk);
		#1;
		chk(stat.in_wait, 1'b1);
		chk(stat.done, 1'b0);
		chk(wait_n, 3);
		@(posedge clk);
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		#1;
		chk(stat, 3'h0);
		chk(wait_n, 0);
		$display("test refuse and reset done");
	endtask

	// Asynchronous READY costs at least one waitstate.
	task automatic t_async();
		run(1'b1, 1'b1, 1'b1, 6'h02, -1);
		chk(wait_n, 1);
		chk(n, 3);
		chk(n_wt, 1);
		$display("test async done");
	endtask

	// Main sequence.
	initial begin
		reset = 1'b1;
		start = 1'b0;
		want = 1'b0;
		cfg = '0;
		n_fail = 0;
		num_checks = 0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		t_noready();
		t_sync();
		t_wait();
		t_refuse_reset();
		t_async();
		tally_and_finish();
	end
endmodule
